// ==== logic/iem_params.svh ====
`ifndef IEM_PARAMS_SVH
`define IEM_PARAMS_SVH

// ****************************************
// Register map
// ****************************************
`define IEM_MASK_ADDR 8'ha8
`define IEM_MASK_RESET 8'h00
`define IEM_BIT_BASE 5'h15

// ****************************************
// Field positions in the enable register
// ****************************************
`define IEM_POS_GLOBAL 7
`define IEM_POS_SPI 6
`define IEM_POS_TIMER2 5
`define IEM_POS_SERIAL 4
`define IEM_POS_TIMER1 3
`define IEM_POS_EXT1 2
`define IEM_POS_TIMER0 1
`define IEM_POS_EXT0 0

// ****************************************
// Timing
// ****************************************
`define IEM_REQ_LATENCY 1

`endif

// ==== logic/iem_pkg.sv ====
package iem_pkg;

    // Enable register layout, bit 7 down to bit 0
    typedef struct packed {
        logic global_irq_enable;
        logic spi_irq_enable;
        logic timer2_irq_enable;
        logic serial_port_irq_enable;
        logic timer1_irq_enable;
        logic ext_irq1_enable;
        logic timer0_irq_enable;
        logic ext_irq0_enable;
    } iem_mask_type;

    // One request per source, same order as enable bits 6..0
    typedef struct packed {
        logic spi;
        logic timer2;
        logic serial_port;
        logic timer1;
        logic ext1;
        logic timer0;
        logic ext0;
    } iem_req_type;

    // Raw source inputs as seen from the peripherals
    typedef struct packed {
        logic spi_irq;
        logic timer2_high_overflow_flag;
        logic timer2_low_overflow_flag;
        logic serial_port_irq;
        logic timer1_overflow_flag;
        logic ext_irq1_pin;
        logic timer0_overflow_flag;
        logic ext_irq0_pin;
    } iem_src_type;

    // Special-function-register access request
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
        logic bit_wr;
        logic [7:0] bit_addr;
        logic bit_data;
    } iem_sfr_type;

    // Whole state of the top module
    typedef struct packed {
        iem_mask_type mask;
        iem_req_type req;
        logic [7:0] rdata;
    } iem_state_type;

endpackage

// ==== logic/iem_gate.sv ====
`timescale 1ns/1ns

// ****************************************
// Per-source gating by enable and global enable
// ****************************************
module iem_gate #(
    parameter int NUM_SRC = 7
) (
    input wire logic global_en_in,
    input wire logic [NUM_SRC-1:0] enable_in,
    input wire logic [NUM_SRC-1:0] raw_in,
    output logic [NUM_SRC-1:0] gated_out
);

    // A clear global enable overrides every individual bit
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        assign gated_out[i] = global_en_in & enable_in[i] & raw_in[i];
    end

endmodule

// ==== logic/iem_top.sv ====
`timescale 1ns/1ns
`include "iem_params.svh"

// Summary of operation
// - Bit 6 gates all SPI requests
// - Bit 5 gates Timer 2 low/high overflow
// - Bit 4 gates the UART request
// - Bit 3 gates Timer 1 overflow flag
// - Bit 2 gates external interrupt 1 input
module iem_top (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire iem_pkg::iem_sfr_type sfr_in,
    input wire iem_pkg::iem_src_type src_in,
    output logic [7:0] sfr_rdata_out,
    output iem_pkg::iem_mask_type mask_out,
    output iem_pkg::iem_req_type irq_req_out
);

    // ****************************************
    // Address decode
    // ****************************************

    // Byte address hits the enable register
    function automatic logic byte_hit(input logic [7:0] addr);
        byte_hit = (addr == `IEM_MASK_ADDR);
    endfunction

    // Bit address hits one bit of the enable register
    function automatic logic bit_hit(input logic [7:0] addr);
        bit_hit = (addr[7:3] == `IEM_BIT_BASE);
    endfunction

    // ****************************************
    // State
    // ****************************************
    iem_pkg::iem_state_type state_r;
    iem_pkg::iem_state_type state_nxt;
    iem_pkg::iem_req_type raw_req;
    logic [6:0] gated;

    // Fold peripheral flags into one request per source
    always_comb begin
        raw_req.spi = src_in.spi_irq;
        raw_req.timer2 = src_in.timer2_low_overflow_flag | src_in.timer2_high_overflow_flag;
        raw_req.serial_port = src_in.serial_port_irq;
        raw_req.timer1 = src_in.timer1_overflow_flag;
        raw_req.ext1 = src_in.ext_irq1_pin;
        raw_req.timer0 = src_in.timer0_overflow_flag;
        raw_req.ext0 = src_in.ext_irq0_pin;
    end

    // Gating uses the stored mask, so a write takes effect next cycle
    iem_gate #(
        .NUM_SRC(7)
    ) u_gate (
        .global_en_in(state_r.mask.global_irq_enable),
        .enable_in(state_r.mask[6:0]),
        .raw_in(raw_req),
        .gated_out(gated)
    );

    // Next state: register writes, read data, gated requests
    always_comb begin
        state_nxt = state_r;
        state_nxt.req = iem_pkg::iem_req_type'(gated);
        // Unmapped reads return zero rather than holding stale data
        if (sfr_in.rd) begin
            state_nxt.rdata = byte_hit(sfr_in.addr) ? state_r.mask : 8'h00;
        end
        // Byte write, then a bit write may refine one field
        if (sfr_in.wr && byte_hit(sfr_in.addr)) begin
            state_nxt.mask = sfr_in.wdata;
        end
        if (sfr_in.bit_wr && bit_hit(sfr_in.bit_addr)) begin
            state_nxt.mask[sfr_in.bit_addr[2:0]] = sfr_in.bit_data;
        end
    end

    // Single register stage for all state
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_r <= '{mask: `IEM_MASK_RESET, req: '0, rdata: 8'h00};
        end else if (ce_in) begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign sfr_rdata_out = state_r.rdata;
    assign mask_out = state_r.mask;
    assign irq_req_out = state_r.req;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    // Helper: clock enable delayed by one cycle, cleared in reset
    logic past_ce;
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            past_ce <= 1'b0;
        end else begin
            past_ce <= ce_in;
        end
    end

    a_spi_gate: assert property (
        ce_in |=> irq_req_out.spi == ($past(state_r.mask.global_irq_enable)
            & $past(state_r.mask.spi_irq_enable) & $past(src_in.spi_irq)))
        else $error("SPI request not gated by its enable");

    a_timer2_either: assert property (
        (ce_in && state_r.mask.global_irq_enable && state_r.mask.timer2_irq_enable
            && (src_in.timer2_low_overflow_flag || src_in.timer2_high_overflow_flag))
        |=> irq_req_out.timer2)
        else $error("Timer 2 flag did not raise a request");

    a_serial_block: assert property (
        (ce_in && !state_r.mask.serial_port_irq_enable) |=> !irq_req_out.serial_port)
        else $error("UART request passed while disabled");

    a_serial_pass: assert property (
        (ce_in && state_r.mask.global_irq_enable && state_r.mask.serial_port_irq_enable
            && src_in.serial_port_irq) |=> irq_req_out.serial_port)
        else $error("UART request lost while enabled");

    a_timer1_gate: assert property (
        ce_in |=> irq_req_out.timer1 == ($past(state_r.mask.global_irq_enable)
            & $past(state_r.mask.timer1_irq_enable) & $past(src_in.timer1_overflow_flag)))
        else $error("Timer 1 request mismatch");

    a_ext1_gate: assert property (
        ce_in |=> irq_req_out.ext1 == ($past(state_r.mask.global_irq_enable)
            & $past(state_r.mask.ext_irq1_enable) & $past(src_in.ext_irq1_pin)))
        else $error("External 1 request mismatch");

    a_global_off: assert property (
        (ce_in && !state_r.mask.global_irq_enable) |=> irq_req_out == '0)
        else $error("Request passed with global enable clear");

    a_low_sources: assert property (
        ce_in |=> {irq_req_out.timer0, irq_req_out.ext0} == ({2{$past(state_r.mask.global_irq_enable)}}
            & {$past(state_r.mask.timer0_irq_enable), $past(state_r.mask.ext_irq0_enable)}
            & {$past(src_in.timer0_overflow_flag), $past(src_in.ext_irq0_pin)}))
        else $error("Timer 0 or external 0 request mismatch");

    a_write_lands: assert property (
        (ce_in && sfr_in.wr && sfr_in.addr == `IEM_MASK_ADDR && !sfr_in.bit_wr)
        |=> mask_out == $past(sfr_in.wdata))
        else $error("Byte write not stored");

    a_freeze_hold: assert property (
        !ce_in |=> $stable(state_r))
        else $error("State moved with clock enable low");

    a_read_back: assert property (
        (ce_in && sfr_in.rd && sfr_in.addr == `IEM_MASK_ADDR) |=> sfr_rdata_out == $past(mask_out))
        else $error("Read data does not match the register");

    // ****************************************
    // Blocking checks
    // ****************************************

    // A cleared SPI enable must hold its request low
    a_spi_block: assert property (
        (ce_in && !state_r.mask.spi_irq_enable) |=> !irq_req_out.spi)
        else $error("SPI request passed while disabled");

    // Either Timer 2 flag alone is enough, none gives nothing
    a_timer2_or: assert property (
        ce_in |=> irq_req_out.timer2 == ($past(state_r.mask.global_irq_enable)
            & $past(state_r.mask.timer2_irq_enable)
            & ($past(src_in.timer2_low_overflow_flag) | $past(src_in.timer2_high_overflow_flag))))
        else $error("Timer 2 request mismatch");

    // A cleared Timer 2 enable blocks both flags
    a_timer2_block: assert property (
        (ce_in && !state_r.mask.timer2_irq_enable) |=> !irq_req_out.timer2)
        else $error("Timer 2 request passed while disabled");

    // Overflow ignored while Timer 1 is masked
    a_timer1_block: assert property (
        (ce_in && !state_r.mask.timer1_irq_enable) |=> !irq_req_out.timer1)
        else $error("Timer 1 request passed while disabled");

    // Pin ignored while external 1 is masked
    a_ext1_block: assert property (
        (ce_in && !state_r.mask.ext_irq1_enable) |=> !irq_req_out.ext1)
        else $error("External 1 request passed while disabled");

    // ****************************************
    // Register access checks
    // ****************************************

    // Reset must clear every output, so this one stays live in reset
    a_reset_clear: assert property (disable iff (1'b0)
        rst_in |=> (mask_out == `IEM_MASK_RESET) && (irq_req_out == '0) && (sfr_rdata_out == 8'h00))
        else $error("Outputs not cleared by reset");

    // A bit write stores the addressed bit
    a_bit_write: assert property (
        (ce_in && sfr_in.bit_wr && bit_hit(sfr_in.bit_addr))
        |=> mask_out[$past(sfr_in.bit_addr[2:0])] == $past(sfr_in.bit_data))
        else $error("Bit write not stored");

    // Unmapped reads must not leak old register data
    a_unmapped_read: assert property (
        (ce_in && sfr_in.rd && !byte_hit(sfr_in.addr)) |=> sfr_rdata_out == 8'h00)
        else $error("Unmapped read returned data");

    // Without a hitting write the mask must not move
    a_mask_quiet: assert property (
        (!(sfr_in.wr && byte_hit(sfr_in.addr)) && !(sfr_in.bit_wr && bit_hit(sfr_in.bit_addr)))
        |=> $stable(mask_out))
        else $error("Mask changed without a write");

    c_spi_fwd: cover property (ce_in && irq_req_out.spi);
    c_timer2_high: cover property (ce_in && src_in.timer2_high_overflow_flag
        && !src_in.timer2_low_overflow_flag ##1 irq_req_out.timer2);
    c_bit_write: cover property (ce_in && sfr_in.bit_wr && sfr_in.bit_addr == 8'haf);
    c_freeze: cover property (past_ce && !ce_in);
    // Byte and bit write landing in one cycle
    c_pair_write: cover property (ce_in && sfr_in.wr && byte_hit(sfr_in.addr)
        && sfr_in.bit_wr && bit_hit(sfr_in.bit_addr));

endmodule

// ==== sim/iem_cpu_model.sv ====
`timescale 1ns/1ns

// ****************************************
// CPU side: sticky record of any request seen
// ****************************************
module iem_cpu_model (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clear_in,
    input wire iem_pkg::iem_req_type req_in,
    output logic [6:0] seen_out
);
    // Sticky so that a one-cycle glitch is still caught later
    always_ff @(posedge core_clk_in) begin
        if (rst_in || clear_in) begin
            seen_out <= 7'h00;
        end else begin
            seen_out <= seen_out | req_in;
        end
    end
endmodule

// ==== sim/iem_top_tb.sv ====
`timescale 1ns/1ns

module iem_top_tb;
    logic core_clk_in;
    logic rst_in;
    logic ce_in;
    logic clear;
    iem_pkg::iem_sfr_type sfr;
    iem_pkg::iem_src_type src;
    logic [7:0] rdata;
    iem_pkg::iem_mask_type mask;
    iem_pkg::iem_req_type req;
    logic [6:0] seen;
    int n_mismatch;
    int n_compared;
    logic [7:0] masks [3] = '{8'hff, 8'h7f, 8'h80};

    iem_top dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in), .sfr_in(sfr),
        .src_in(src), .sfr_rdata_out(rdata), .mask_out(mask), .irq_req_out(req));
    iem_cpu_model cpu (.core_clk_in(core_clk_in), .rst_in(rst_in), .clear_in(clear),
        .req_in(req), .seen_out(seen));

    // ****************************************
    // Clock and access tasks
    // ****************************************
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    // Inputs always move 1 ns after the rising edge
    task automatic step();
        @(posedge core_clk_in);
        #1;
    endtask

    task automatic cmp(string name, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(logic [7:0] addr, logic [7:0] data);
        sfr.addr = addr;
        sfr.wdata = data;
        sfr.wr = 1'b1;
        step();
        sfr.wr = 1'b0;
        // Idle edge so a following call never re-raises the strobe at once
        step();
    endtask

    // Byte write and bit write on the same edge
    task automatic wr_pair(logic [7:0] data, logic [2:0] pos, logic val);
        sfr.addr = 8'ha8;
        sfr.wdata = data;
        sfr.bit_addr = 8'ha8 + 8'(pos);
        sfr.bit_data = val;
        sfr.wr = 1'b1;
        sfr.bit_wr = 1'b1;
        step();
        sfr.wr = 1'b0;
        sfr.bit_wr = 1'b0;
        step();
    endtask

    task automatic bit_wr(logic [2:0] pos, logic val);
        sfr.bit_addr = 8'ha8 + 8'(pos);
        sfr.bit_data = val;
        sfr.bit_wr = 1'b1;
        step();
        sfr.bit_wr = 1'b0;
        step();
    endtask

    task automatic rd(logic [7:0] addr, logic [7:0] exp);
        sfr.addr = addr;
        sfr.rd = 1'b1;
        step();
        sfr.rd = 1'b0;
        cmp("read", exp, rdata);
        step();
    endtask

    // Expected gated requests worked out from mask and raw sources
    function automatic logic [7:0] exp_req(logic [7:0] m, logic [7:0] s);
        logic [6:0] r;
        r = {s[7], s[6] | s[5], s[4], s[3], s[2], s[1], s[0]} & m[6:0];
        return m[7] ? {1'b0, r} : 8'h00;
    endfunction

    task automatic test_done();
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        #100000;
        n_mismatch++;
        test_done();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        n_mismatch = 0;
        n_compared = 0;
        rst_in = 1'b1;
        ce_in = 1'b1;
        clear = 1'b0;
        sfr = '0;
        src = '0;
        repeat (3) step();
        rst_in = 1'b0;
        rd(8'ha8, 8'h00);
        cmp("mask_reset", 8'h00, mask);
        // Every raw source against each mask, timer2 flags one at a time
        for (int j = 0; j < 8; j++) begin
            for (int k = 0; k < 3; k++) begin
                wr(8'ha8, masks[k]);
                src = iem_pkg::iem_src_type'(8'h01 << j);
                step();
                step();
                cmp("req", exp_req(masks[k], src), {1'b0, req});
            end
        end
        // Global off with all sources raised: nothing may ever leak
        wr(8'ha8, 8'h7f);
        src = 8'hff;
        clear = 1'b1;
        step();
        clear = 1'b0;
        repeat (5) step();
        cmp("leak", 8'h00, {1'b0, seen});
        rd(8'ha8, 8'h7f);
        // Unmapped write ignored, unmapped read gives zero
        wr(8'ha9, 8'h00);
        rd(8'ha8, 8'h7f);
        rd(8'hb8, 8'h00);
        // Bit write of the global enable opens every gate
        bit_wr(3'h7, 1'b1);
        step();
        cmp("bit_global", 8'h7f, {1'b0, req});
        bit_wr(3'h6, 1'b0);
        step();
        cmp("bit_spi", 8'h3f, {1'b0, req});
        // Frozen clock enable blocks writes
        ce_in = 1'b0;
        wr(8'ha8, 8'h00);
        ce_in = 1'b1;
        cmp("mask_freeze", 8'hbf, mask);
        rd(8'ha8, 8'hbf);
        // Bit write overrides one bit of a same-cycle byte write
        wr_pair(8'h00, 3'h7, 1'b1);
        cmp("pair", 8'h80, mask);
        step();
        cmp("pair_req", 8'h00, {1'b0, req});
        test_done();
    end
endmodule
